// ### logic/i2c_controller.sv
/*
  two-wire bus controller, master or slave, with control, status and data
  registers on a classic wishbone slave port.
  assumes open-drain pads outside: an enable high pulls the line low, and
  the pad level comes back on i_scl / i_sda, asynchronous to i_core_clk.
*/
// Overview of operation
// - control bit 7 enables the controller; zero disables it
// - control bit 6 gates the interrupt request
// - bit 5 rising makes a start and master, or arbitration lost if busy; falling between bytes makes a stop
// - bit 4 selects transmit or receive; held at 1 for address cycles
// - received data is acked low unless bit 3 is set
// - writing 1 to bit 2 makes a repeated start as master; reads zero
// - a repeated start at a wrong moment counts as arbitration lost
// - status bit 7 sets per byte; cleared by data read rx or write tx
// - status bit 6 sets on own or general call match; control write clears
// - status bit 5 sets on start, clears on stop, any mode
// - status bit 4 sets on lost arbitration; write 1 clears it
// - status bit 2 holds the calling direction bit while addressed
// - status bit 1 sets on byte done, address match, arbitration loss
// - status bit 0 holds the ack sampled after each sent byte
// - master transmit: data write sends a byte msb first
// - master receive: data read starts the next byte
// - after an address match slave mode behaves the same way
// - transfers start only when bit 4 matches; tx read starts nothing
// - receive mode data reads return the last received byte
// - general call is answered when its enable bit is 1, or while own address is zero
// - lost arbitration drops sda at once, slave receive, no stop
`timescale 1ns/1ps
module i2c_controller #(
  parameter int unsigned QUARTER_CYC = i2c_controller_pkg::QUARTER_CYC
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_srst,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  output logic             o_irq,
  input  wire logic        i_scl,
  output logic             o_scl,
  output logic             o_scl_oe,
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oe
);

  if (QUARTER_CYC < 2 || QUARTER_CYC > 65535) begin : g_chk
    $error("QUARTER_CYC out of range 2..65535");
  end

  typedef struct packed {
    i2c_controller_pkg::state_t st;
    logic       en;
    logic       ie;
    logic       master_select;
    logic       tx;
    logic       ackd;
    logic       gcen;
    logic [6:0] own;
    logic       done;
    logic       aas;
    logic       busy;
    logic       arbitration_lost_flag;
    logic       slave_direction_flag;
    logic       ifl;
    logic       ack_received_n;
    logic       addr_ph;
    logic       go;
    logic [7:0] sh;
    logic [7:0] rx;
    logic [3:0] bitn;
    logic [1:0] ph;
    logic [15:0] qc;
    logic       scl1;
    logic       scl2;
    logic       sclp;
    logic       sda1;
    logic       sda2;
    logic       sdap;
    logic       scl_oe;
    logic       sda_oe;
    logic       irq;
    logic       ack;
    logic [7:0] dat;
  } core_t;

  core_t s_reg;
  core_t s_next;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a[7:2] == ofs[7:2];
  endfunction

  logic take;
  logic wr;
  logic rd;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic qt;
  logic mst_up;
  logic mst_dn;
  logic repeated_start_request;
  logic match;

  assign take = i_wb_cyc && i_wb_stb && !s_reg.ack;
  assign wr = take && i_wb_we && i_wb_sel[0];
  assign rd = take && !i_wb_we;
  // only second-stage and later copies are looked at here
  assign start_det = s_reg.sclp && s_reg.scl2 && s_reg.sdap && !s_reg.sda2;
  assign stop_det = s_reg.sclp && s_reg.scl2 && !s_reg.sdap && s_reg.sda2;
  assign scl_rise = !s_reg.sclp && s_reg.scl2;
  assign scl_fall = s_reg.sclp && !s_reg.scl2;
  assign qt = s_reg.qc == 16'(QUARTER_CYC - 1);
  assign mst_up = wr && hit(i_wb_adr, i2c_controller_pkg::OFS_CTRL)
                  && !s_reg.master_select && i_wb_dat[i2c_controller_pkg::CTL_MST];
  assign mst_dn = wr && hit(i_wb_adr, i2c_controller_pkg::OFS_CTRL)
                  && s_reg.master_select && !i_wb_dat[i2c_controller_pkg::CTL_MST];
  assign repeated_start_request = wr && hit(i_wb_adr, i2c_controller_pkg::OFS_CTRL)
                && i_wb_dat[i2c_controller_pkg::CTL_REPEATED_START_REQUEST];
  assign match = (s_reg.sh[7:1] == s_reg.own)
                 || (s_reg.gcen && s_reg.sh[7:1] == i2c_controller_pkg::GC_ADDR);

  always_comb begin
    s_next = s_reg;
    s_next.scl1 = i_scl;
    s_next.scl2 = s_reg.scl1;
    s_next.sclp = s_reg.scl2;
    s_next.sda1 = i_sda;
    s_next.sda2 = s_reg.sda1;
    s_next.sdap = s_reg.sda2;
    s_next.irq = s_reg.ifl && s_reg.ie;
    s_next.ack = take;
    // quarter-bit timer; held in the high phase while someone stretches scl
    if (qt || (s_reg.st == i2c_controller_pkg::ST_BIT && s_reg.ph == 2'd2
               && !s_reg.scl2)) begin
      s_next.qc = '0;
    end else begin
      s_next.qc = s_reg.qc + 16'd1;
    end
    if (take) begin
      s_next.dat = 8'h00;
      if (hit(i_wb_adr, i2c_controller_pkg::OFS_CTRL)) begin
        s_next.dat = {s_reg.en, s_reg.ie, s_reg.master_select, s_reg.tx, s_reg.ackd,
                      3'b000};
      end else if (hit(i_wb_adr, i2c_controller_pkg::OFS_STAT)) begin
        s_next.dat = {s_reg.done, s_reg.aas, s_reg.busy, s_reg.arbitration_lost_flag, 1'b0,
                      s_reg.slave_direction_flag, s_reg.ifl, s_reg.ack_received_n};
      end else if (hit(i_wb_adr, i2c_controller_pkg::OFS_DATA)) begin
        s_next.dat = s_reg.rx;
      end else if (hit(i_wb_adr, i2c_controller_pkg::OFS_CTRL2)) begin
        s_next.dat = {s_reg.gcen, 7'h00};
      end else if (hit(i_wb_adr, i2c_controller_pkg::OFS_OWN)) begin
        s_next.dat = {s_reg.own, 1'b0};
      end
    end
    // software effects first, so hardware events below win over clears
    if (wr && hit(i_wb_adr, i2c_controller_pkg::OFS_CTRL)) begin
      s_next.en = i_wb_dat[i2c_controller_pkg::CTL_EN];
      s_next.ie = i_wb_dat[i2c_controller_pkg::CTL_IE];
      s_next.master_select = i_wb_dat[i2c_controller_pkg::CTL_MST];
      s_next.tx = i_wb_dat[i2c_controller_pkg::CTL_TX];
      s_next.ackd = i_wb_dat[i2c_controller_pkg::CTL_ACKD];
      s_next.aas = 1'b0;
    end
    if (wr && hit(i_wb_adr, i2c_controller_pkg::OFS_STAT)) begin
      if (i_wb_dat[i2c_controller_pkg::STS_ARBITRATION_LOST_FLAG]) begin
        s_next.arbitration_lost_flag = 1'b0;
      end
      if (i_wb_dat[i2c_controller_pkg::STS_IF]) begin
        s_next.ifl = 1'b0;
      end
    end
    if (wr && hit(i_wb_adr, i2c_controller_pkg::OFS_CTRL2)) begin
      s_next.gcen = i_wb_dat[i2c_controller_pkg::C2_GCEN];
    end
    if (wr && hit(i_wb_adr, i2c_controller_pkg::OFS_OWN)) begin
      s_next.own = i_wb_dat[7:1];
    end
    if (wr && hit(i_wb_adr, i2c_controller_pkg::OFS_DATA) && s_reg.tx) begin
      s_next.sh = i_wb_dat[7:0];
      s_next.done = 1'b0;
      s_next.go = 1'b1;
    end
    if (rd && hit(i_wb_adr, i2c_controller_pkg::OFS_DATA) && !s_reg.tx) begin
      s_next.done = 1'b0;
      s_next.go = 1'b1;
    end
    if (start_det) begin
      s_next.busy = 1'b1;
    end
    if (stop_det) begin
      s_next.busy = 1'b0;
    end
    case (s_reg.st)
      i2c_controller_pkg::ST_IDLE: begin
        if (mst_up) begin
          if (s_reg.busy) begin
            s_next.master_select = 1'b0;
            s_next.arbitration_lost_flag = 1'b1;
            s_next.ifl = 1'b1;
          end else begin
            s_next.st = i2c_controller_pkg::ST_START;
            s_next.ph = 2'd0;
            s_next.go = 1'b0;
          end
        end
      end
      i2c_controller_pkg::ST_START: begin
        if (qt) begin
          s_next.ph = s_reg.ph + 2'd1;
          if (s_reg.ph == 2'd0) begin
            s_next.sda_oe = 1'b1;
          end else begin
            s_next.scl_oe = 1'b1;
            s_next.st = i2c_controller_pkg::ST_HOLD;
            s_next.addr_ph = 1'b1;
          end
        end
      end
      i2c_controller_pkg::ST_HOLD: begin
        if (s_reg.master_select && mst_dn) begin
          s_next.st = i2c_controller_pkg::ST_STOP;
          s_next.ph = 2'd0;
        end else if (s_reg.master_select && repeated_start_request) begin
          s_next.st = i2c_controller_pkg::ST_RSTRT;
          s_next.ph = 2'd0;
        end else if (s_next.go) begin
          s_next.go = 1'b0;
          s_next.bitn = 4'd0;
          s_next.ph = 2'd0;
          if (s_reg.master_select) begin
            s_next.st = i2c_controller_pkg::ST_BIT;
          end else begin
            // slave releases its stretch and puts out the first bit
            s_next.st = i2c_controller_pkg::ST_SLV;
            s_next.scl_oe = 1'b0;
            s_next.sda_oe = s_next.tx && !s_next.sh[7];
          end
        end
      end
      i2c_controller_pkg::ST_BIT: begin
        if (qt) begin
          s_next.ph = s_reg.ph + 2'd1;
          case (s_reg.ph)
            2'd0: begin
              if (s_reg.bitn < 4'd8) begin
                s_next.sda_oe = s_reg.tx && !s_reg.sh[7];
              end else begin
                s_next.sda_oe = !s_reg.tx && !s_reg.ackd;
              end
            end
            2'd1: s_next.scl_oe = 1'b0;
            2'd2: begin
              if (s_reg.bitn < 4'd8) begin
                s_next.sh = {s_reg.sh[6:0], s_reg.sda2};
                if (s_reg.tx && !s_reg.sda_oe && !s_reg.sda2) begin
                  // lost: let the winner finish the byte, no stop
                  s_next.st = i2c_controller_pkg::ST_SLV;
                  s_next.sda_oe = 1'b0;
                  s_next.scl_oe = 1'b0;
                  s_next.master_select = 1'b0;
                  s_next.tx = 1'b0;
                  s_next.arbitration_lost_flag = 1'b1;
                  s_next.ifl = 1'b1;
                end
              end else if (s_reg.tx) begin
                s_next.ack_received_n = s_reg.sda2;
              end
            end
            default: begin
              s_next.scl_oe = 1'b1;
              if (s_reg.bitn == 4'd8) begin
                s_next.st = i2c_controller_pkg::ST_HOLD;
                s_next.sda_oe = 1'b0;
                s_next.addr_ph = 1'b0;
                s_next.done = 1'b1;
                s_next.ifl = 1'b1;
                if (!s_reg.tx) begin
                  s_next.rx = s_reg.sh;
                end
              end else begin
                s_next.bitn = s_reg.bitn + 4'd1;
              end
            end
          endcase
        end
      end
      i2c_controller_pkg::ST_RSTRT: begin
        if (qt) begin
          s_next.ph = s_reg.ph + 2'd1;
          case (s_reg.ph)
            2'd0: s_next.sda_oe = 1'b0;
            2'd1: s_next.scl_oe = 1'b0;
            2'd2: s_next.sda_oe = 1'b1;
            default: begin
              s_next.scl_oe = 1'b1;
              s_next.st = i2c_controller_pkg::ST_HOLD;
              s_next.addr_ph = 1'b1;
            end
          endcase
        end
      end
      i2c_controller_pkg::ST_STOP: begin
        if (qt) begin
          s_next.ph = s_reg.ph + 2'd1;
          case (s_reg.ph)
            2'd0: s_next.sda_oe = 1'b1;
            2'd1: s_next.scl_oe = 1'b0;
            2'd2: s_next.sda_oe = 1'b0;
            default: s_next.st = i2c_controller_pkg::ST_IDLE;
          endcase
        end
      end
      i2c_controller_pkg::ST_SLV: begin
        if (scl_rise) begin
          if (s_reg.bitn < 4'd8) begin
            s_next.sh = {s_reg.sh[6:0], s_reg.sda2};
          end else if (s_reg.tx && !s_reg.addr_ph) begin
            s_next.ack_received_n = s_reg.sda2;
          end
        end
        if (scl_fall) begin
          if (s_reg.bitn == 4'd7) begin
            s_next.bitn = 4'd8;
            if (s_reg.addr_ph) begin
              if (match) begin
                s_next.aas = 1'b1;
                s_next.slave_direction_flag = s_reg.sh[0];
                s_next.done = 1'b1;
                s_next.ifl = 1'b1;
                s_next.sda_oe = 1'b1;
              end else begin
                // not for us: sit out until the next start or stop
                s_next.st = i2c_controller_pkg::ST_IDLE;
              end
            end else if (!s_reg.tx) begin
              s_next.sda_oe = !s_reg.ackd;
              s_next.rx = s_reg.sh;
              s_next.done = 1'b1;
              s_next.ifl = 1'b1;
            end else begin
              s_next.sda_oe = 1'b0;
            end
          end else if (s_reg.bitn == 4'd8) begin
            // stretch scl until software services the data register
            s_next.st = i2c_controller_pkg::ST_HOLD;
            s_next.sda_oe = 1'b0;
            s_next.scl_oe = 1'b1;
            s_next.addr_ph = 1'b0;
            if (s_reg.tx && !s_reg.addr_ph) begin
              s_next.done = 1'b1;
              s_next.ifl = 1'b1;
            end
          end else begin
            s_next.bitn = s_reg.bitn + 4'd1;
            s_next.sda_oe = s_reg.tx && !s_reg.addr_ph && !s_reg.sh[7];
          end
        end
      end
      default: s_next.st = i2c_controller_pkg::ST_IDLE;
    endcase
    if (repeated_start_request && (!s_reg.master_select || s_reg.st != i2c_controller_pkg::ST_HOLD)) begin
      s_next.arbitration_lost_flag = 1'b1;
      s_next.ifl = 1'b1;
      s_next.master_select = 1'b0;
      s_next.sda_oe = 1'b0;
      s_next.scl_oe = 1'b0;
      s_next.st = i2c_controller_pkg::ST_IDLE;
    end
    if (start_det && !s_reg.master_select) begin
      s_next.st = i2c_controller_pkg::ST_SLV;
      // the scl fall that closes the start wraps this to zero
      s_next.bitn = 4'd15;
      s_next.addr_ph = 1'b1;
      s_next.sda_oe = 1'b0;
      s_next.scl_oe = 1'b0;
    end
    if (stop_det && !s_reg.master_select) begin
      s_next.st = i2c_controller_pkg::ST_IDLE;
      s_next.sda_oe = 1'b0;
      s_next.scl_oe = 1'b0;
    end
    if (!s_next.en) begin
      s_next.st = i2c_controller_pkg::ST_IDLE;
      s_next.sda_oe = 1'b0;
      s_next.scl_oe = 1'b0;
      s_next.master_select = 1'b0;
      s_next.busy = 1'b0;
      s_next.aas = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_wb_dat = {24'h000000, s_reg.dat};
  assign o_wb_ack = s_reg.ack;
  assign o_irq = s_reg.irq;
  assign o_scl = 1'b0;
  assign o_sda = 1'b0;
  assign o_scl_oe = s_reg.scl_oe;
  assign o_sda_oe = s_reg.sda_oe;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);

  sequence s_ctrl_read;
    rd && hit(i_wb_adr, i2c_controller_pkg::OFS_CTRL);
  endsequence
  sequence s_clean_start;
    s_reg.st == i2c_controller_pkg::ST_IDLE && !s_reg.busy && mst_up
    && i_wb_dat[i2c_controller_pkg::CTL_EN];
  endsequence

  property p_repeated_start_request_zero;
    s_ctrl_read |=> o_wb_ack && !o_wb_dat[2];
  endproperty
  a_repeated_start_request_zero: assert property (p_repeated_start_request_zero)
    else $error("repeated start bit read back as one");

  property p_irq;
    s_reg.ifl && s_reg.ie ##1 s_reg.ifl && s_reg.ie |=> o_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output missing while pending and enabled");

  property p_irq_off;
    !s_reg.ie |=> !o_irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt output high while disabled");

  property p_off;
    !s_reg.en |-> !o_scl_oe && !o_sda_oe
                  && s_reg.st == i2c_controller_pkg::ST_IDLE;
  endproperty
  a_off: assert property (p_off)
    else $error("disabled controller drives the bus");

  property p_arbitration_lost_flag_hold;
    s_reg.arbitration_lost_flag && !(wr && hit(i_wb_adr, i2c_controller_pkg::OFS_STAT)
                    && i_wb_dat[4]) |=> s_reg.arbitration_lost_flag;
  endproperty
  a_arbitration_lost_flag_hold: assert property (p_arbitration_lost_flag_hold)
    else $error("arbitration flag cleared without a write of one");

  property p_ifl_cause;
    $rose(s_reg.ifl) |-> s_reg.done || s_reg.aas || s_reg.arbitration_lost_flag;
  endproperty
  a_ifl_cause: assert property (p_ifl_cause)
    else $error("pending flag set without a cause");

  property p_busy;
    $rose(s_reg.busy) |-> $past(start_det);
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy set without a start");

  property p_tx_clear;
    wr && hit(i_wb_adr, i2c_controller_pkg::OFS_DATA) && s_reg.tx
    && s_reg.st == i2c_controller_pkg::ST_HOLD |=> !s_reg.done;
  endproperty
  a_tx_clear: assert property (p_tx_clear)
    else $error("byte done flag not cleared by a transmit write");

  property p_lose;
    $rose(s_reg.arbitration_lost_flag) |-> !o_sda_oe && !s_reg.master_select;
  endproperty
  a_lose: assert property (p_lose)
    else $error("still master or driving sda after losing");

  sequence s_start_edge;
    s_reg.st == i2c_controller_pkg::ST_START && s_reg.ph == 2'd0 && qt
    && !take;
  endsequence

  // start check is one cycle on; the sda check is tied to the quarter timer, so slow rates stay cheap
  property p_start;
    s_clean_start |=> s_reg.st == i2c_controller_pkg::ST_START;
  endproperty
  a_start: assert property (p_start)
    else $error("no start condition after master select");

  property p_start_sda;
    s_start_edge |=> o_sda_oe && !o_scl_oe;
  endproperty
  a_start_sda: assert property (p_start_sda)
    else $error("start did not pull sda low with scl high");

  property p_rd_rx;
    rd && hit(i_wb_adr, i2c_controller_pkg::OFS_DATA)
    |=> o_wb_dat[7:0] == $past(s_reg.rx);
  endproperty
  a_rd_rx: assert property (p_rd_rx)
    else $error("data read did not return the received byte");

endmodule

// ### logic/i2c_controller_pkg.sv
/*
  register map, field positions, reset values, state encoding and bus
  timing for the two-wire bus controller. assumes a 250 MHz core clock.
*/
package i2c_controller_pkg;

  // byte addresses on the register bus
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_STAT  = 8'h04;
  localparam logic [7:0] OFS_DATA  = 8'h08;
  localparam logic [7:0] OFS_CTRL2 = 8'h0c;
  localparam logic [7:0] OFS_OWN   = 8'h10;

  // bus_control_one fields
  localparam int CTL_EN   = 7;
  localparam int CTL_IE   = 6;
  localparam int CTL_MST  = 5;
  localparam int CTL_TX   = 4;
  localparam int CTL_ACKD = 3;
  localparam int CTL_REPEATED_START_REQUEST = 2;

  // bus_status_flags fields
  localparam int STS_DONE = 7;
  localparam int STS_AAS  = 6;
  localparam int STS_BUSY = 5;
  localparam int STS_ARBITRATION_LOST_FLAG = 4;
  localparam int STS_SRW  = 2;
  localparam int STS_IF   = 1;
  localparam int STS_ACK_RECEIVED_N = 0;

  // second control register
  localparam int C2_GCEN = 7;

  // reset values and the general call address
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [7:0] CTRL2_RST    = 8'h00;
  localparam logic [6:0] OWN_ADDR_RST = 7'h00;
  localparam logic [6:0] GC_ADDR      = 7'h00;

  // timing: one quarter of a 100 kbit/s bit period
  localparam int CLK_MHZ     = 250;
  localparam int QUARTER_NS  = 2500;
  localparam int QUARTER_CYC = (QUARTER_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_HOLD,
    ST_BIT,
    ST_RSTRT,
    ST_STOP,
    ST_SLV
  } state_t;

endpackage

// ### testbench/bus_target_model.sv
/*
  behavioural target on the two-wire bus: acks its own address, keeps the
  last byte written to it and returns i_tx_byte when read.
  assumes pull-ups on both lines, so a released sda reads high.
*/
`timescale 1ns/1ps
module bus_target_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic [7:0] i_tx_byte,
  output logic            o_sda_pull
);
  int         bit_n = -1;
  logic       on = 0;
  logic       adr_ph = 0;
  logic       hit = 0;
  logic       rd = 0;
  logic       mack = 1;
  logic [7:0] sh = 8'h00;
  logic [7:0] got = 8'h00;
  logic [7:0] tx = 8'h00;
  initial o_sda_pull = 0;
  always @(negedge i_sda) if (i_scl) begin
    on = 1;
    adr_ph = 1;
    bit_n = -1;
  end
  always @(posedge i_sda) if (i_scl) on = 0;
  always @(posedge i_scl) begin
    if (bit_n < 8)
      sh = {sh[6:0], i_sda};
    if (bit_n == 8)
      mack = i_sda;
  end
  // data only changes while scl is low, as the wire demands
  always @(negedge i_scl) if (on) begin
    bit_n = bit_n + 1;
    if (bit_n == 8) begin
      if (adr_ph) begin
        hit = sh[7:1] == ADDR;
        rd = sh[0];
      end else if (!rd)
        got = sh;
      o_sda_pull = hit && (adr_ph || !rd);
    end else if (bit_n == 9) begin
      tx = i_tx_byte;
      rd = rd && (adr_ph || !mack);  // a missing ack ends a read
      o_sda_pull = hit && rd && !tx[7];
      on = hit;
      adr_ph = 0;
      bit_n = 0;
    end else if (bit_n > 0)
      o_sda_pull = hit && rd && !adr_ph && !tx[7 - bit_n];
  end
endmodule

// ### testbench/tb.sv
/*
  self-checking bench: wishbone register accesses, a master write and a
  master read against the target model, and a slave receive driven by
  the bench acting as a second master on the wire.
  assumes QUARTER_CYC of 4, so one bit on the wire takes 64 ns.
*/
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] CTRL = i2c_controller_pkg::OFS_CTRL;
  localparam logic [7:0] STAT = i2c_controller_pkg::OFS_STAT;
  localparam logic [7:0] DATA = i2c_controller_pkg::OFS_DATA;
  logic        clk = 0;
  logic        srst = 1;
  logic        cyc = 0;
  logic        stb = 0;
  logic        we = 0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h1;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        ack;
  logic        irq;
  logic        scl_oe;
  logic        sda_oe;
  logic        pull;
  int          mismatches = 0;
  int          checks = 0;
  logic        m_scl = 0;
  logic        m_sda = 0;
  logic        sack;
  wire         scl = ~(scl_oe | m_scl);
  wire         sda = ~(sda_oe | pull | m_sda);
  i2c_controller #(.QUARTER_CYC(4)) i_i2c_controller (
    .i_core_clk(clk), .i_srst(srst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .o_irq(irq), .i_scl(scl),
    .o_scl(), .o_scl_oe(scl_oe), .i_sda(sda), .o_sda(),
    .o_sda_oe(sda_oe));
  bus_target_model i_bus_target_model (
    .i_scl(scl), .i_sda(sda), .i_tx_byte(8'hc3), .o_sda_pull(pull));
  initial forever #2 clk = ~clk;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // holds the request until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, d);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 0;
    stb <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input string nm, input logic [7:0] e);
    wb(0, a, 8'h00);
    chk(nm, q, {24'h0, e});
  endtask
  task automatic poll(input logic [7:0] m, want);
    int n;
    n = 0;
    do begin
      wb(0, STAT, 8'h00);
      n++;
    end while ((q[7:0] & m) !== want && n < 400);
    // a poll that runs out counts against the run
    if ((q[7:0] & m) !== want) mismatches++;
  endtask
  task automatic byte_end(input logic [7:0] e);
    poll(8'h80, 8'h80);
    rd(STAT, "stat", e);
    wb(1, STAT, 8'h02);
  endtask
  // bench as a second master; waits out any stretch on scl
  task automatic wire_bit(input logic b, output logic s);
    m_sda <= !b;
    repeat (4) @(posedge clk);
    m_scl <= 0;
    do @(posedge clk); while (scl !== 1'b1);
    repeat (4) @(posedge clk);
    s = sda;
    repeat (4) @(posedge clk);
    m_scl <= 1;
    repeat (4) @(posedge clk);
  endtask
  task automatic wire_byte(input logic [7:0] b, output logic a);
    for (int i = 7; i >= 0; i--) begin
      wire_bit(b[i], a);
    end
    wire_bit(1'b1, a);
  endtask
  task automatic wire_start;
    m_sda <= 1;
    repeat (8) @(posedge clk);
    m_scl <= 1;
    repeat (4) @(posedge clk);
  endtask
  task automatic wire_stop;
    m_sda <= 1;
    repeat (4) @(posedge clk);
    m_scl <= 0;
    do @(posedge clk); while (scl !== 1'b1);
    repeat (8) @(posedge clk);
    m_sda <= 0;
    repeat (8) @(posedge clk);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    rd(CTRL, "ctrl", 8'h00);
    rd(STAT, "stat", 8'h00);
    rd(8'h20, "unmapped", 8'h00);
    wb(1, CTRL, 8'h30);
    repeat (40) @(posedge clk);
    chk("oe", {scl_oe, sda_oe}, 2'b00);
    chk("oe", {scl_oe, sda_oe}, 2'b00);
    wb(1, CTRL, 8'h84);
    rd(CTRL, "ctrl", 8'h80);
    rd(STAT, "stat", 8'h12);
    chk("irq", irq, 1'b0);
    wb(1, CTRL, 8'hc0);
    @(posedge clk);
    chk("irq", irq, 1'b1);
    wb(1, STAT, 8'h12);
    rd(STAT, "stat", 8'h00);
    chk("irq", irq, 1'b0);
    wb(1, CTRL, 8'hb0);
    poll(8'h20, 8'h20);
    wb(1, DATA, 8'h22);
    byte_end(8'ha3);
    wb(1, CTRL, 8'hb4);
    wb(1, DATA, 8'h54);
    byte_end(8'ha2);
    wb(1, DATA, 8'h5a);
    rd(STAT, "stat", 8'h20);
    byte_end(8'ha2);
    chk("got", i_bus_target_model.got, 8'h5a);
    wb(1, CTRL, 8'hb4);
    wb(1, DATA, 8'h55);
    byte_end(8'ha2);
    wb(1, CTRL, 8'ha8);
    wb(0, DATA, 8'h00);
    byte_end(8'ha2);
    chk("mack", i_bus_target_model.mack, 1'b1);
    wb(1, CTRL, 8'hb8);
    rd(DATA, "data", 8'hc3);
    rd(STAT, "stat", 8'ha0);
    wb(1, CTRL, 8'h80);
    poll(8'h20, 8'h00);
    chk("busy", q[7:0] & 8'h20, 8'h00);
    wb(1, i2c_controller_pkg::OFS_OWN, 8'h2a);
    wire_start;
    wire_byte(8'h2a, sack);
    chk("slave ack", sack, 1'b0);
    rd(STAT, "stat", 8'he2);
    wb(1, CTRL, 8'h80);
    rd(STAT, "stat", 8'ha2);
    wb(0, DATA, 8'h00);
    wire_byte(8'h96, sack);
    chk("slave ack", sack, 1'b0);
    rd(DATA, "data", 8'h96);
    wire_stop;
    poll(8'h20, 8'h00);
    chk("busy", q[7:0] & 8'h20, 8'h00);
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish;
  end
endmodule
